// ### shared/csd_pkg.sv
// Constants and types for the chip-select option decoder
package csd_pkg;

	// ==========================================================
	// Option word field positions
	localparam int OPT_MODE_BIT   = 15;
	localparam int OPT_BYTE_LSB   = 13;
	localparam int OPT_RW_LSB     = 11;
	localparam int OPT_STROBE_ALIGN_BIT   = 10;
	localparam int OPT_ACK_LSB    = 6;
	localparam int OPT_SPACE_LSB  = 4;
	localparam int OPT_FETCH_LSB  = 2;
	localparam int OPT_IDLE_BIT   = 1;
	localparam int OPT_INTERRUPT_ACK_CYCLE_BIT   = 0;

	// ==========================================================
	// Option word reset value
	localparam logic [15:0] OPT_RESET = 16'h0000;

	// ==========================================================
	// Field encodings
	localparam logic [1:0] BYTE_OFF    = 2'h0;
	localparam logic [1:0] BYTE_LOWER  = 2'h1;
	localparam logic [1:0] BYTE_UPPER  = 2'h2;
	localparam logic [1:0] BYTE_BOTH   = 2'h3;
	localparam logic [1:0] RW_OFF      = 2'h0;
	localparam logic [1:0] RW_READ     = 2'h1;
	localparam logic [1:0] RW_WRITE    = 2'h2;
	localparam logic [1:0] RW_BOTH     = 2'h3;
	localparam logic [1:0] SPACE_CPU   = 2'h0;
	localparam logic [1:0] SPACE_USER  = 2'h1;
	localparam logic [1:0] SPACE_SUPV  = 2'h2;
	localparam logic [1:0] SPACE_SU    = 2'h3;
	localparam logic [1:0] FETCH_ANY   = 2'h0;
	localparam logic [1:0] FETCH_DATA  = 2'h1;
	localparam logic [1:0] FETCH_PROG  = 2'h2;
	localparam logic [3:0] ACK_EXTERN  = 4'hF;
	localparam logic [3:0] ACK_BASE_CLK = 4'h2;

	// ==========================================================
	// Block size decode
	localparam logic [2:0] BLK_2K = 3'h0;
	localparam int ADDR_W = 24;
	localparam int BASE_LSB = 11;

	// ==========================================================
	// Cycle sequencer states
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_EXTW  = 3'b011,
		ST_SYNC  = 3'b100,
		ST_GAP   = 3'b101
	} csd_state_t;

endpackage : csd_pkg

// ### src/csd_decode.sv
// Chip-select option decode and cycle timing for one select line
`timescale 1ns/1ps

module csd_decode
	import csd_pkg::*;
#(
	parameter int ACK_W = 4
)
(
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                SRST,
	// Option and base configuration
	input  wire logic [15:0]         OPTION_WORD,
	input  wire logic [12:0]         BASE_ADDR,
	input  wire logic [2:0]          BLOCK_SIZE,
	input  wire logic                IS_LINE_A,
	input  wire logic                ACK_CYCLE_CTRL,
	// Cycle request from the bus sequencer
	input  wire logic                CYCLE_START,
	input  wire logic [ADDR_W-1:0]   CYCLE_ADDR,
	input  wire logic                CYCLE_READ,
	input  wire logic                CYCLE_UPPER,
	input  wire logic                CYCLE_LOWER,
	input  wire logic                CYCLE_CPU_SPACE,
	input  wire logic                CYCLE_PROGRAM,
	input  wire logic                ADDRESS_STROBE,
	input  wire logic                DATA_STROBE,
	input  wire logic                E_CLOCK_DONE,
	// External acknowledge pin
	input  wire logic                TRANSFER_ACKNOWLEDGE_N,
	// Outputs
	output logic                     SELECT_N,
	output logic                     CYCLE_DONE,
	output logic                     E_CYCLE_PENDING,
	output logic                     EXT_TERMINATE,
	output logic                     BUS_IDLE_GAP,
	output logic                     MATCH
);

	// ==========================================================
	// Helpers
	function automatic logic [12:0] blk_mask(input logic [2:0] sz);
		logic [12:0] m;
		m = 13'h1FFF;
		unique case (sz)
			3'h0: m = 13'h1FFF;
			3'h1: m = 13'h1FFC;
			3'h2: m = 13'h1FF8;
			3'h3: m = 13'h1FE0;
			3'h4: m = 13'h1FC0;
			3'h5: m = 13'h1F80;
			3'h6: m = 13'h1F00;
			3'h7: m = 13'h1E00;
		endcase
		return m;
	endfunction : blk_mask

	function automatic logic two_bit_qual(input logic [1:0] f,
		input logic a, input logic b);
		return (f[0] & a) | (f[1] & b);
	endfunction : two_bit_qual

	// ==========================================================
	// Pin synchronisers
	logic [2:0] ack_sync_q;
	logic [2:0] ack_sync_d;
	logic       ack_pin;

	always_comb
	begin
		ack_sync_d = {ack_sync_q[1:0], ~TRANSFER_ACKNOWLEDGE_N};
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			ack_sync_q <= 3'h0;
		else
			ack_sync_q <= ack_sync_d;
	end

	assign ack_pin = ack_sync_q[1];

	// ==========================================================
	// Field decode
	logic       f_sync;
	logic [1:0] f_byte;
	logic [1:0] f_rw;
	logic       f_strobe_align;
	logic [3:0] f_ack;
	logic [1:0] f_space;
	logic [1:0] f_fetch;
	logic       f_idle;
	logic       f_interrupt_ack_cycle;
	logic       addr_hit;
	logic       byte_ok;
	logic       rw_ok;
	logic       space_ok;
	logic       fetch_ok;
	logic       interrupt_ack_cycle_ok;
	logic       qual_ok;

	always_comb
	begin
		f_sync  = OPTION_WORD[OPT_MODE_BIT];
		f_byte  = OPTION_WORD[OPT_BYTE_LSB +: 2];
		f_rw    = OPTION_WORD[OPT_RW_LSB +: 2];
		f_strobe_align  = OPTION_WORD[OPT_STROBE_ALIGN_BIT];
		f_ack   = OPTION_WORD[OPT_ACK_LSB +: ACK_W];
		f_space = OPTION_WORD[OPT_SPACE_LSB +: 2];
		f_fetch = OPTION_WORD[OPT_FETCH_LSB +: 2];
		f_idle  = OPTION_WORD[OPT_IDLE_BIT];
		f_interrupt_ack_cycle  = OPTION_WORD[OPT_INTERRUPT_ACK_CYCLE_BIT];
		addr_hit = ((CYCLE_ADDR[ADDR_W-1:BASE_LSB] ^ BASE_ADDR)
			& blk_mask(BLOCK_SIZE)) == 13'h0000;
		byte_ok = two_bit_qual(f_byte, CYCLE_LOWER, CYCLE_UPPER);
		rw_ok = two_bit_qual(f_rw, CYCLE_READ, ~CYCLE_READ);
		if (CYCLE_CPU_SPACE)
			space_ok = (f_space == SPACE_CPU);
		else
			space_ok = f_space[1];
		unique case (f_fetch)
			FETCH_ANY:  fetch_ok = 1'b1;
			FETCH_DATA: fetch_ok = ~CYCLE_PROGRAM;
			FETCH_PROG: fetch_ok = CYCLE_PROGRAM;
			default:    fetch_ok = 1'b0;
		endcase
		// Acknowledge cycle on line A needs both bits
		if (CYCLE_CPU_SPACE)
			interrupt_ack_cycle_ok = ~IS_LINE_A | (f_interrupt_ack_cycle & ACK_CYCLE_CTRL);
		else
			interrupt_ack_cycle_ok = 1'b1;
		qual_ok = addr_hit & byte_ok & rw_ok & space_ok & fetch_ok
			& interrupt_ack_cycle_ok;
	end

	// ==========================================================
	// Cycle sequencer
	csd_state_t state_q;
	csd_state_t state_d;
	logic [3:0] wait_q;
	logic [3:0] wait_d;
	logic       sel_q;
	logic       sel_d;
	logic       done_q;
	logic       done_d;
	logic       epend_q;
	logic       epend_d;
	logic       ext_q;
	logic       ext_d;
	logic       gap_q;
	logic       gap_d;
	logic       match_q;
	logic       match_d;
	logic       idle_q;
	logic       idle_d;
	logic       strobe;

	always_comb
	begin
		state_d = state_q;
		wait_d  = wait_q;
		sel_d   = sel_q;
		done_d  = 1'b0;
		epend_d = epend_q;
		ext_d   = ext_q;
		gap_d   = 1'b0;
		match_d = match_q;
		idle_d  = idle_q;
		strobe  = f_strobe_align ? DATA_STROBE : ADDRESS_STROBE;
		unique case (state_q)
			ST_IDLE:
			begin
				if (CYCLE_START)
				begin
					match_d = qual_ok;
					idle_d  = f_idle;
					ext_d   = CYCLE_CPU_SPACE & IS_LINE_A & qual_ok & ~f_sync;
					if (qual_ok && f_sync)
					begin
						epend_d = 1'b1;
						sel_d   = 1'b1;
						state_d = ST_SYNC;
					end
					else
					begin
						if (qual_ok && f_ack == 4'h0 && strobe)
							sel_d = 1'b1;
						state_d = ST_ADDR;
					end
				end
			end
			ST_ADDR:
			begin
				if (match_q && strobe)
					sel_d = 1'b1;
				if (!match_q)
				begin
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end
				else if (f_ack == ACK_EXTERN || ext_q)
					state_d = ST_EXTW;
				else if (f_ack == 4'h0)
				begin
					sel_d   = 1'b0;
					done_d  = 1'b1;
					state_d = idle_q ? ST_GAP : ST_IDLE;
				end
				else
				begin
					wait_d  = f_ack - 4'h1;
					state_d = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (wait_q == 4'h0)
				begin
					sel_d   = 1'b0;
					done_d  = 1'b1;
					state_d = idle_q ? ST_GAP : ST_IDLE;
				end
				else
					wait_d = wait_q - 4'h1;
			end
			ST_EXTW:
			begin
				// Negate on a fresh acknowledge only
				if (ack_pin && !ack_sync_q[2])
				begin
					sel_d   = 1'b0;
					done_d  = 1'b1;
					ext_d   = 1'b0;
					state_d = idle_q ? ST_GAP : ST_IDLE;
				end
			end
			ST_SYNC:
			begin
				// Ends with E-clock cycle, ack field unused
				if (E_CLOCK_DONE)
				begin
					sel_d   = 1'b0;
					epend_d = 1'b0;
					done_d  = 1'b1;
					state_d = idle_q ? ST_GAP : ST_IDLE;
				end
			end
			ST_GAP:
			begin
				gap_d   = 1'b1;
				state_d = ST_IDLE;
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			state_q <= ST_IDLE;
			wait_q  <= 4'h0;
			sel_q   <= 1'b0;
			done_q  <= 1'b0;
			epend_q <= 1'b0;
			ext_q   <= 1'b0;
			gap_q   <= 1'b0;
			match_q <= 1'b0;
			idle_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			wait_q  <= wait_d;
			sel_q   <= sel_d;
			done_q  <= done_d;
			epend_q <= epend_d;
			ext_q   <= ext_d;
			gap_q   <= gap_d;
			match_q <= match_d;
			idle_q  <= idle_d;
		end
	end

	// ==========================================================
	// Outputs
	assign SELECT_N        = ~sel_q;
	assign CYCLE_DONE      = done_q;
	assign E_CYCLE_PENDING = epend_q;
	assign EXT_TERMINATE   = ext_q;
	assign BUS_IDLE_GAP    = gap_q;
	assign MATCH           = match_q;

endmodule : csd_decode

// ### testbench/csd_decode_assertions.sv
// Property checker for the chip-select option decoder
`timescale 1ns/1ps
module csd_chk
	import csd_pkg::*;
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        SRST,
	// Watched configuration
	input wire logic        IS_LINE_A,
	input wire logic        ACK_CYCLE_CTRL,
	input wire logic [15:0] OPTION_WORD,
	// Watched outputs
	input wire logic        SELECT_N,
	input wire logic        CYCLE_DONE,
	input wire logic        E_CYCLE_PENDING,
	input wire logic        EXT_TERMINATE,
	input wire logic        BUS_IDLE_GAP,
	input wire logic        MATCH
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_reset_quiet: assert property (disable iff (1'b0)
		SRST |=> SELECT_N && !CYCLE_DONE && !MATCH) else $error("reset");
	a_gap_follows: assert property (
		CYCLE_DONE && MATCH |=> BUS_IDLE_GAP == OPTION_WORD[OPT_IDLE_BIT])
		else $error("idle gap");
	a_gap_cause: assert property (
		BUS_IDLE_GAP |-> $past(CYCLE_DONE)) else $error("gap cause");
	a_sel_match: assert property (
		!SELECT_N |-> MATCH) else $error("select no match");
	a_pend_mode: assert property (
		E_CYCLE_PENDING |-> OPTION_WORD[OPT_MODE_BIT]) else $error("pend");
	a_sync_pend: assert property (
		!SELECT_N && OPTION_WORD[OPT_MODE_BIT] |-> E_CYCLE_PENDING)
		else $error("sync pend");
	a_field_off: assert property (
		OPTION_WORD[14:13] == BYTE_OFF || OPTION_WORD[12:11] == RW_OFF
		|-> SELECT_N) else $error("disabled select");
	a_ext_term: assert property (
		EXT_TERMINATE |-> IS_LINE_A && OPTION_WORD[0] && ACK_CYCLE_CTRL)
		else $error("ext term");
	a_done_pulse: assert property (
		CYCLE_DONE |-> SELECT_N ##1 !CYCLE_DONE) else $error("done");
endmodule : csd_chk

bind csd_decode csd_chk chk_u (.CLK, .SRST, .IS_LINE_A, .ACK_CYCLE_CTRL,
	.OPTION_WORD, .SELECT_N, .CYCLE_DONE, .E_CYCLE_PENDING, .EXT_TERMINATE,
	.BUS_IDLE_GAP, .MATCH);

// ### testbench/csd_ext_dev.sv
// External device that ends selected cycles with an acknowledge
`timescale 1ns/1ps
module csd_ext_dev
(
	// Bus side
	input  wire logic       clk,
	input  wire logic       select_n,
	input  wire logic [3:0] dly,
	output logic            ack_n
);
	logic [3:0] cnt_q = 4'h0;
	initial ack_n = 1'b1;
	always @(posedge clk)
	begin
		if (select_n)
		begin
			cnt_q <= 4'h0;
			ack_n <= 1'b1;
		end
		else
		begin
			if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
			ack_n <= !(cnt_q >= dly);
		end
	end
endmodule : csd_ext_dev

// ### testbench/tb.sv
// Self-checking bench for the chip-select option decoder
`timescale 1ns/1ps
module tb import csd_pkg::*;;
	logic CLK = 0, SRST = 1, CYCLE_START = 0, CYCLE_READ = 0, CYCLE_UPPER = 0;
	logic CYCLE_LOWER = 0, CYCLE_CPU_SPACE = 0, CYCLE_PROGRAM = 0;
	logic ADDRESS_STROBE = 0, DATA_STROBE = 0, E_CLOCK_DONE = 0;
	logic IS_LINE_A = 0, ACK_CYCLE_CTRL = 0, TRANSFER_ACKNOWLEDGE_N;
	logic SELECT_N, CYCLE_DONE, E_CYCLE_PENDING, EXT_TERMINATE;
	logic BUS_IDLE_GAP, MATCH, m_seen, sel_seen, pend_seen, e;
	logic [15:0] OPTION_WORD = 16'h0000;
	logic [12:0] BASE_ADDR = 13'h0000;
	logic [2:0]  BLOCK_SIZE = 3'h0;
	logic [23:0] CYCLE_ADDR = 24'h000000;
	logic [3:0]  dly = 4'h0;
	logic [31:0] rs = 32'h00000038, r;
	int          err_total = 0, checked = 0, lat, lat0, k;
	always #50 CLK = ~CLK;
	csd_decode dut_u (.CLK, .SRST, .OPTION_WORD, .BASE_ADDR, .BLOCK_SIZE,
		.IS_LINE_A, .ACK_CYCLE_CTRL, .CYCLE_START, .CYCLE_ADDR, .CYCLE_READ,
		.CYCLE_UPPER, .CYCLE_LOWER, .CYCLE_CPU_SPACE, .CYCLE_PROGRAM,
		.ADDRESS_STROBE, .DATA_STROBE, .E_CLOCK_DONE, .TRANSFER_ACKNOWLEDGE_N,
		.SELECT_N, .CYCLE_DONE, .E_CYCLE_PENDING, .EXT_TERMINATE,
		.BUS_IDLE_GAP, .MATCH);
	csd_ext_dev ext_u (.clk(CLK), .select_n(SELECT_N), .dly(dly),
		.ack_n(TRANSFER_ACKNOWLEDGE_N));
	function logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	function automatic logic expm();
		int s;
		logic sp;
		s = BLOCK_SIZE == 0 ? 0 : BLOCK_SIZE < 3 ? BLOCK_SIZE + 1 : BLOCK_SIZE + 2;
		sp = CYCLE_CPU_SPACE ? OPTION_WORD[5:4] == SPACE_CPU && (!IS_LINE_A
			|| OPTION_WORD[0] && ACK_CYCLE_CTRL) : OPTION_WORD[5];
		return (CYCLE_ADDR[23:11] >> s) == (BASE_ADDR >> s) && sp
			&& (OPTION_WORD[13] && CYCLE_LOWER || OPTION_WORD[14] && CYCLE_UPPER)
			&& (CYCLE_READ ? OPTION_WORD[11] : OPTION_WORD[12])
			&& (OPTION_WORD[3:2] == FETCH_ANY
			|| OPTION_WORD[3:2] == FETCH_DATA && !CYCLE_PROGRAM
			|| OPTION_WORD[3:2] == FETCH_PROG && CYCLE_PROGRAM);
	endfunction : expm
	task chk(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task end_sim;
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	// Runs one bus cycle, ecd is the cycle index of the E-clock end
	task run(input int ecd);
		int n;
		sel_seen = 0;
		pend_seen = 0;
		@(negedge CLK);
		CYCLE_START = 1;
		for (n = 0; n < 60; n++)
		begin
			@(negedge CLK);
			CYCLE_START = 0;
			E_CLOCK_DONE = n == ecd;
			if (n == 1) m_seen = MATCH;
			if (SELECT_N === 1'b0) sel_seen = 1;
			if (E_CYCLE_PENDING === 1'b1) pend_seen = 1;
			if (CYCLE_DONE === 1'b1) break;
		end
		lat = n;
		@(negedge CLK);
		E_CLOCK_DONE = 0;
		@(negedge CLK);
		if (n == 60)
		begin
			err_total++;
			end_sim;
		end
	endtask : run
	initial
	begin
		repeat (12) @(negedge CLK);
		SRST = 0;
		ADDRESS_STROBE = 1;
		DATA_STROBE = 1;
		repeat (200)
		begin
			r = xs();
			OPTION_WORD = {1'b0, r[14:0]};
			if (r[31]) OPTION_WORD[14:11] = 4'hF;
			if (r[31]) OPTION_WORD[3:2] = FETCH_ANY;
			dly = {1'b0, r[18:16]};
			BLOCK_SIZE = r[22:20];
			{IS_LINE_A, ACK_CYCLE_CTRL, CYCLE_READ, CYCLE_UPPER} = r[26:23];
			CYCLE_LOWER = r[27] | !r[26];
			{CYCLE_CPU_SPACE, CYCLE_PROGRAM} = r[29:28];
			BASE_ADDR = 13'(xs());
			CYCLE_ADDR = 24'(xs());
			if (r[30]) CYCLE_ADDR[23:11] = BASE_ADDR;
			e = expm();
			run(-1);
			chk("match", 16'(m_seen), 16'(e));
			chk("select", 16'(sel_seen), 16'(e));
		end
		{IS_LINE_A, CYCLE_READ, CYCLE_LOWER, CYCLE_CPU_SPACE} = 4'h6;
		CYCLE_ADDR[23:11] = BASE_ADDR;
		for (k = 0; k < 15; k++)
		begin
			OPTION_WORD = 16'h7822 | 16'(k << 6);
			run(-1);
			if (k == 0) lat0 = lat;
			chk("waits", 16'(lat - lat0), 16'(k));
			chk("access clocks", 16'(lat + 1), 16'(k + ACK_BASE_CLK));
			chk("wait select", 16'(sel_seen), 16'h0001);
		end
		OPTION_WORD = 16'h7BE2;
		dly = 4'h2;
		run(-1);
		lat0 = lat;
		dly = 4'h6;
		run(-1);
		chk("ext ack", 16'(lat - lat0), 16'h0004);
		OPTION_WORD = 16'hF822;
		run(3);
		lat0 = lat;
		chk("pending", 16'(pend_seen), 16'h0001);
		OPTION_WORD = 16'hFBE2;
		dly = 4'h0;
		run(3);
		chk("sync len", 16'(lat), 16'(lat0));
		{ADDRESS_STROBE, DATA_STROBE} = 2'h1;
		OPTION_WORD = 16'h7C62;
		run(-1);
		chk("data strobe", 16'(sel_seen), 16'h0001);
		OPTION_WORD = 16'h7862;
		run(-1);
		chk("addr strobe", 16'(sel_seen), 16'h0000);
		end_sim;
	end
endmodule : tb
